// *** cpw_pkg.sv ***
/*
  Shared constants and an attribute check for the coherency slave port write path.
  Assumes a single 40 MHz clock shared by both ends.
*/
package cpw_pkg;
  // ----------------------------------------------------------------
  // Widths, store depth and byte address shift
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int STRB_W = 8;
  localparam int LEN_W = 4;
  localparam int CACHE_W = 4;
  localparam int SIDE_W = 5;
  localparam int ID_W = 3;
  localparam int MEM_WORDS = 16;
  localparam int MEM_IDX_W = 4;
  localparam int BYTE_SHIFT = 3;

  // ----------------------------------------------------------------
  // Sideband fields and inner attribute codes
  // ----------------------------------------------------------------
  localparam int SIDE_SHARED_BIT = 0;
  localparam int SIDE_ATTR_LSB = 1;
  localparam logic [3:0] ATTR_STRONG = 4'h0;
  localparam logic [3:0] ATTR_DEVICE = 4'h1;
  localparam logic [3:0] ATTR_NONCACHE = 4'h3;
  localparam logic [3:0] ATTR_WTHROUGH = 4'h6;
  localparam logic [3:0] ATTR_WBACK_NOALLOC = 4'h7;
  localparam logic [3:0] ATTR_WBACK_ALLOC = 4'hF;

  // ----------------------------------------------------------------
  // Response codes and cache type bits
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CACHE_BUFFERABLE_BIT = 0;
  localparam int CACHE_CACHEABLE_BIT = 1;

  function automatic logic attrLegal(input logic [3:0] attr);
    attrLegal = (attr == ATTR_STRONG) || (attr == ATTR_DEVICE) || (attr == ATTR_NONCACHE) ||
                (attr == ATTR_WTHROUGH) || (attr == ATTR_WBACK_NOALLOC) ||
                (attr == ATTR_WBACK_ALLOC);
  endfunction : attrLegal
endpackage : cpw_pkg

// *** cpw_link_if.sv ***
/*
  Write address, data and response channels between master and port.
  Assumes both ends share clock and rstn.
*/
`timescale 1ns/1ps
interface cpw_link_if
  import cpw_pkg::*;
(
  input wire logic clock,
  input wire logic rstn
);
  logic awValid;
  logic awReady;
  logic [ADDR_W-1:0] coh_wr_address;
  logic [LEN_W-1:0] coh_wr_burst_length;
  logic [1:0] coh_wr_beat_size;
  logic [CACHE_W-1:0] coh_wr_cache_type;
  logic coh_wr_lock_type;
  logic [SIDE_W-1:0] coh_wr_sideband;
  logic [ID_W-1:0] awId;
  logic wValid;
  logic wReady;
  logic [DATA_W-1:0] coh_wr_beat_data;
  logic [STRB_W-1:0] coh_wr_byte_strobe;
  logic coh_wr_final_beat;
  logic bValid;
  logic bReady;
  logic [1:0] coh_wr_response_code;
  logic [ID_W-1:0] bId;

  modport master (
    input clock, rstn, awReady, wReady, bValid, coh_wr_response_code, bId,
    output awValid, coh_wr_address, coh_wr_burst_length, coh_wr_beat_size, coh_wr_cache_type,
    output coh_wr_lock_type, coh_wr_sideband, awId, wValid, coh_wr_beat_data,
    output coh_wr_byte_strobe, coh_wr_final_beat, bReady
  );
  modport port (
    input clock, rstn, awValid, coh_wr_address, coh_wr_burst_length, coh_wr_beat_size,
    input coh_wr_cache_type, coh_wr_lock_type, coh_wr_sideband, awId, wValid,
    input coh_wr_beat_data, coh_wr_byte_strobe, coh_wr_final_beat, bReady,
    output awReady, wReady, bValid, coh_wr_response_code, bId
  );
endinterface : cpw_link_if

// *** cpw_master.sv ***
/*
  External master end: takes one write burst request from user logic
  and plays it onto the link, then returns the response.
  Assumes user holds beat data valid until taken.
*/
`timescale 1ns/1ps
module cpw_master
  import cpw_pkg::*;
(
  cpw_link_if.master link,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [ADDR_W-1:0] reqAddress,
  input wire logic [LEN_W-1:0] reqLength,
  input wire logic [CACHE_W-1:0] reqCache,
  input wire logic [SIDE_W-1:0] reqSideband,
  input wire logic reqExclusive,
  input wire logic [ID_W-1:0] reqId,
  input wire logic beatValid,
  output logic beatReady,
  input wire logic [DATA_W-1:0] beatData,
  input wire logic [STRB_W-1:0] beatStrobe,
  output logic doneValid,
  output logic [1:0] doneResp
);
  typedef enum {MS_IDLE, MS_ADDR, MS_DATA, MS_RESP} cpw_mstate_t;
  typedef struct packed {
    cpw_mstate_t st;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] beat;
    logic [CACHE_W-1:0] cache;
    logic [SIDE_W-1:0] side;
    logic lock;
    logic [ID_W-1:0] id;
    logic doneValid;
    logic [1:0] doneResp;
  } cpw_mreg_t;
  cpw_mreg_t r, next_r;

  // ----------------------------------------------------------------
  // Link drive
  // ----------------------------------------------------------------
  assign link.awValid = (r.st == MS_ADDR);
  assign link.coh_wr_address = r.addr;
  assign link.coh_wr_burst_length = r.len; // [R1]
  assign link.coh_wr_beat_size = 2'h3;
  assign link.coh_wr_cache_type = r.cache; // [R2]
  assign link.coh_wr_sideband = r.side; // [R3]
  assign link.coh_wr_lock_type = r.lock;
  assign link.awId = r.id;
  assign link.wValid = (r.st == MS_DATA) && beatValid;
  assign link.coh_wr_beat_data = beatData; // [R4]
  assign link.coh_wr_byte_strobe = beatStrobe; // [R4]
  assign link.coh_wr_final_beat = (r.beat == r.len);
  assign link.bReady = (r.st == MS_RESP);
  assign beatReady = (r.st == MS_DATA) && link.wReady;
  assign reqReady = (r.st == MS_IDLE);
  assign doneValid = r.doneValid;
  assign doneResp = r.doneResp;

  // Sequencer
  always_comb begin
    next_r = r;
    next_r.doneValid = 1'b0;
    case (r.st)
      MS_IDLE: begin
        if (reqValid) begin
          next_r.addr = reqAddress;
          next_r.len = reqLength;
          next_r.cache = reqCache;
          next_r.side = reqSideband;
          next_r.lock = reqExclusive;
          next_r.id = reqId;
          next_r.beat = '0;
          next_r.st = MS_ADDR;
        end
      end
      MS_ADDR: if (link.awReady) next_r.st = MS_DATA; // [R5]
      MS_DATA: begin
        if (link.wValid && link.wReady) begin // [R5]
          next_r.beat = r.beat + 1'b1;
          if (r.beat == r.len) next_r.st = MS_RESP; // [R1]
        end
      end
      MS_RESP: begin
        if (link.bValid) begin // [R5]
          next_r.doneValid = 1'b1;
          next_r.doneResp = link.coh_wr_response_code;
          next_r.st = MS_IDLE;
        end
      end
      default: next_r.st = MS_IDLE;
    endcase
  end

  always_ff @(posedge link.clock or negedge link.rstn) begin
    if (!link.rstn) begin
      r <= '{st: MS_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end
endmodule : cpw_master

// *** cpw_port.sv ***
/*
  Coherency slave port write end: accepts write bursts, buffers beats in a
  two-entry buffer, merges strobed bytes into a small word store and answers.
  Assumes the master keeps to valid/ready signalling on each channel.
*/
`timescale 1ns/1ps
// How it works
// R1 - Burst length sets number of data beats
// R2 - Cache type accepted; only its cacheable bit is recorded per write
// R3 - Sideband carries inner attribute and shared bit
// R4 - 64-bit beats; only strobed bytes update
// R5 - Transfer only when valid and ready high
module cpw_port
  import cpw_pkg::*;
#(
  parameter int WORDS = MEM_WORDS
) (
  cpw_link_if.port link,
  input wire logic [MEM_IDX_W-1:0] peekIndex,
  output logic [DATA_W-1:0] peekData,
  output logic lastCacheable,
  output logic [3:0] lastAttr,
  output logic lastShared,
  output logic lastExclusive
);
  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  // Buffer entry layout and occupancy levels
  localparam int ENTRY_W = DATA_W + STRB_W;
  localparam int BYTE_W = 8;
  localparam int ATTR_W = 4;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;
  localparam logic [1:0] BUF_FULL = 2'h2;

  // Waiting for an address, taking beats, answering
  typedef enum {PS_IDLE, PS_DATA, PS_RESP} cpw_pstate_t;
  // Every register of the port end
  typedef struct packed {
    cpw_pstate_t st;
    logic [MEM_IDX_W-1:0] idx;
    logic [LEN_W-1:0] left;
    logic [ID_W-1:0] id;
    logic bad;
    logic lock;
    logic [1:0] bufCount;
    logic [1:0][ENTRY_W-1:0] buffer; // Oldest beat in entry 0
    logic bValid;
    logic [1:0] resp;
    logic awReady;
    logic wReady;
    logic [WORDS-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] peek;
    logic cacheable;
    logic [3:0] attr;
    logic shared;
    logic excl;
  } cpw_preg_t;
  cpw_preg_t r, next_r;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte merge under strobe
  function automatic logic [DATA_W-1:0] mergeBytes(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] data,
                                                   input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) res[b*BYTE_W +: BYTE_W] = data[b*BYTE_W +: BYTE_W]; // [R4]
    end
    mergeBytes = res;
  endfunction : mergeBytes

  // Inner attribute field of a sideband word
  function automatic logic [ATTR_W-1:0] sidebandAttr(input logic [SIDE_W-1:0] side);
    sidebandAttr = side[SIDE_ATTR_LSB +: ATTR_W]; // [R3]
  endfunction : sidebandAttr

  // Answer for a finished burst: a refused attribute wins over exclusive
  function automatic logic [1:0] burstResp(input logic bad, input logic excl);
    if (bad) begin
      burstResp = RESP_SLVERR;
    end else if (excl) begin
      burstResp = RESP_EXOKAY;
    end else begin
      burstResp = RESP_OKAY;
    end
  endfunction : burstResp

  // Pack a beat and its strobe into one buffer entry
  function automatic logic [ENTRY_W-1:0] packEntry(input logic [DATA_W-1:0] data,
                                                  input logic [STRB_W-1:0] strb);
    packEntry = {data, strb};
  endfunction : packEntry

  // ----------------------------------------------------------------
  // Link outputs and store and attribute status outputs
  // ----------------------------------------------------------------
  assign link.awReady = r.awReady;
  assign link.wReady = r.wReady; // Stall when buffer full
  assign link.bValid = r.bValid;
  assign link.coh_wr_response_code = r.resp;
  assign link.bId = r.id;
  assign peekData = r.peek;
  assign lastCacheable = r.cacheable;
  assign lastAttr = r.attr;
  assign lastShared = r.shared;
  assign lastExclusive = r.excl;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Address, buffer, merge and response
  always_comb begin
    logic push;
    logic pop;
    logic [ENTRY_W-1:0] head;
    push = 1'b0;
    pop = 1'b0;
    head = r.buffer[0];
    next_r = r;
    next_r.peek = r.mem[peekIndex];
    next_r.awReady = 1'b0;
    // Drain one beat per cycle into the store
    if (r.bufCount != BUF_EMPTY) begin
      pop = 1'b1;
      // Beats of a refused burst are dropped here
      if (!r.bad) begin
        next_r.mem[r.idx] = mergeBytes(r.mem[r.idx], head[DATA_W+STRB_W-1:STRB_W],
                                       head[STRB_W-1:0]); // [R4]
      end
      // Word index wraps round the store
      next_r.idx = r.idx + 1'b1;
    end
    // A beat is taken only on valid and ready
    push = link.wValid && link.wReady; // [R5]
    case (r.st)
      // Offer the address channel while idle, latch its fields
      PS_IDLE: begin
        next_r.awReady = 1'b1;
        if (link.awValid && r.awReady) begin // [R5]
          next_r.awReady = 1'b0;
          next_r.idx = link.coh_wr_address[BYTE_SHIFT +: MEM_IDX_W];
          next_r.left = link.coh_wr_burst_length; // [R1]
          next_r.id = link.awId;
          next_r.lock = link.coh_wr_lock_type;
          next_r.cacheable = link.coh_wr_cache_type[CACHE_CACHEABLE_BIT]; // [R2]
          next_r.attr = sidebandAttr(link.coh_wr_sideband); // [R3]
          next_r.shared = link.coh_wr_sideband[SIDE_SHARED_BIT]; // [R3]
          next_r.excl = link.coh_wr_lock_type;
          next_r.bad = !attrLegal(sidebandAttr(link.coh_wr_sideband)); // [R3]
          next_r.st = PS_DATA;
        end
      end
      // Count beats down; the one taken at zero is the last
      PS_DATA: begin
        if (push) begin
          next_r.left = r.left - 1'b1;
          if (r.left == '0) next_r.st = PS_RESP; // [R1]
        end
      end
      // Answer only once the buffer has drained into the store
      PS_RESP: begin
        if (r.bufCount == BUF_EMPTY && !r.bValid) begin
          next_r.bValid = 1'b1;
          next_r.resp = burstResp(r.bad, r.lock);
        end
        if (r.bValid && link.bReady) begin // [R5]
          next_r.bValid = 1'b0;
          next_r.st = PS_IDLE;
        end
      end
      default: begin
        next_r.st = PS_IDLE;
      end
    endcase
    // Two-entry buffer shift: entry 1 moves up as entry 0 drains
    if (pop) begin
      next_r.buffer[0] = r.buffer[1];
    end
    // New beat goes to the first entry left free after the pop
    if (push) begin
      if (r.bufCount == BUF_EMPTY || (pop && r.bufCount == BUF_ONE)) begin
        next_r.buffer[0] = packEntry(link.coh_wr_beat_data, link.coh_wr_byte_strobe); // [R4]
      end else begin
        next_r.buffer[1] = packEntry(link.coh_wr_beat_data, link.coh_wr_byte_strobe); // [R4]
      end
    end
    // Occupancy follows push and pop
    case ({push, pop})
      2'h2: next_r.bufCount = r.bufCount + 2'h1;
      2'h1: next_r.bufCount = r.bufCount - 2'h1;
      default: next_r.bufCount = r.bufCount;
    endcase
    // Ready comes from a flop: low when full or not taking beats
    next_r.wReady = (next_r.st == PS_DATA) && (next_r.bufCount != BUF_FULL); // [R5]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Whole state record, cleared by reset
  always_ff @(posedge link.clock or negedge link.rstn) begin
    if (!link.rstn) begin
      r <= '{st: PS_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end
endmodule : cpw_port

// *** cpw_link_sva.sv ***
/*
  Checker for the write link between master and port ends.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cpw_link_sva
  import cpw_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic awValid,
  input wire logic awReady,
  input wire logic [LEN_W-1:0] coh_wr_burst_length,
  input wire logic coh_wr_lock_type,
  input wire logic [SIDE_W-1:0] coh_wr_sideband,
  input wire logic [ID_W-1:0] awId,
  input wire logic wValid,
  input wire logic wReady,
  input wire logic [DATA_W-1:0] coh_wr_beat_data,
  input wire logic coh_wr_final_beat,
  input wire logic bValid,
  input wire logic bReady,
  input wire logic [1:0] coh_wr_response_code,
  input wire logic [ID_W-1:0] bId
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic open;
  logic lock;
  logic [3:0] cnt;
  logic [3:0] len;
  logic [4:0] side;
  logic [ID_W-1:0] id;
  wire awHs = awValid && awReady;
  wire wHs = wValid && wReady;
  wire legal = side[4:1] inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h7, 4'hF};
  // --------------------------------------------------------------
  // Burst tracking
  // --------------------------------------------------------------
  // Latch address fields, count beats
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {open, lock, cnt, len, side, id} <= '0;
    end else begin
      if (awHs) begin
        {open, lock, cnt, len} <= {1'b1, coh_wr_lock_type, 4'h0, coh_wr_burst_length};
        {side, id} <= {coh_wr_sideband, awId};
      end else if (wHs) begin
        cnt <= cnt + 4'h1;
      end
      if (bValid && bReady) begin
        open <= 1'b0;
      end
    end
  end
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  chk_aw_held: assert property (awValid && !awReady |=> awValid)
    else $error("address valid dropped before ready");
  chk_w_held: assert property (wValid && !wReady |=> wValid && $stable(coh_wr_beat_data))
    else $error("beat changed before ready");
  chk_b_held: assert property (bValid && !bReady |=> bValid && $stable(coh_wr_response_code))
    else $error("response changed before ready");
  chk_aw_closed: assert property (open |-> !awReady)
    else $error("address taken inside open burst");
  chk_beat_final: assert property (wHs |-> coh_wr_final_beat == (cnt == len))
    else $error("final beat marker wrong");
  chk_beat_bound: assert property (wHs |-> open && cnt <= len)
    else $error("beat outside burst");
  chk_resp_code: assert property (bValid |-> coh_wr_response_code ==
      (!legal ? RESP_SLVERR : lock ? RESP_EXOKAY : RESP_OKAY))
    else $error("response code wrong");
  chk_resp_id: assert property (bValid |-> bId == id)
    else $error("response id wrong");
  chk_resp_soon: assert property (wHs && cnt == len |-> ##[2:4] bValid)
    else $error("response late");
  cov_long: cover property (awHs && coh_wr_burst_length == 4'hF);
  cov_err: cover property (bValid && bReady && coh_wr_response_code == RESP_SLVERR);
  cov_excl: cover property (bValid && bReady && coh_wr_response_code == RESP_EXOKAY);
endmodule : cpw_link_sva

// *** testbench.sv ***
/*
  Testbench: plays write bursts through the master end into the port end.
  Assumes the checker and both ends compile before it.
*/
`timescale 1ns/1ps
module testbench;
  import cpw_pkg::*;
  logic clock, rstn, reqValid, reqExclusive, beatValid, reqReady, beatReady, doneValid;
  logic lastCacheable, lastShared, lastExclusive;
  logic [ADDR_W-1:0] reqAddress;
  logic [LEN_W-1:0] reqLength;
  logic [CACHE_W-1:0] reqCache, reqId4, lastAttr;
  logic [SIDE_W-1:0] reqSideband;
  logic [DATA_W-1:0] beatData, peekData;
  logic [STRB_W-1:0] beatStrobe;
  logic [1:0] doneResp;
  logic [MEM_IDX_W-1:0] peekIndex;
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [3:0] attrs [6] = '{ATTR_STRONG, ATTR_DEVICE, ATTR_NONCACHE, ATTR_WTHROUGH,
                           ATTR_WBACK_NOALLOC, ATTR_WBACK_ALLOC};
  int errors, checks_done;
  cpw_link_if link (.clock(clock), .rstn(rstn));
  cpw_master cpw_master_inst (.link(link), .reqValid(reqValid), .reqReady(reqReady),
    .reqAddress(reqAddress), .reqLength(reqLength), .reqCache(reqCache),
    .reqSideband(reqSideband), .reqExclusive(reqExclusive), .reqId(reqId4[2:0]),
    .beatValid(beatValid), .beatReady(beatReady), .beatData(beatData),
    .beatStrobe(beatStrobe), .doneValid(doneValid), .doneResp(doneResp));
  cpw_port #(.WORDS(MEM_WORDS)) cpw_port_inst (.link(link), .peekIndex(peekIndex),
    .peekData(peekData), .lastCacheable(lastCacheable), .lastAttr(lastAttr),
    .lastShared(lastShared), .lastExclusive(lastExclusive));
  cpw_link_sva chk (.clock(clock), .rstn(rstn), .awValid(link.awValid),
    .awReady(link.awReady), .coh_wr_burst_length(link.coh_wr_burst_length),
    .coh_wr_lock_type(link.coh_wr_lock_type), .coh_wr_sideband(link.coh_wr_sideband),
    .awId(link.awId), .wValid(link.wValid), .wReady(link.wReady),
    .coh_wr_beat_data(link.coh_wr_beat_data), .coh_wr_final_beat(link.coh_wr_final_beat),
    .bValid(link.bValid), .bReady(link.bReady),
    .coh_wr_response_code(link.coh_wr_response_code), .bId(link.bId));
  // Clock at 40 MHz
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Bounded wait ran out
  task automatic waited(input int t);
    if (t >= 50) begin
      errors++;
      summarize();
    end
  endtask : waited
  // One burst through the master, model updated beat by beat
  task automatic burst(input logic [31:0] a, input logic [3:0] n, input logic [4:0] sb,
                       input logic ex, input logic [3:0] ca, input logic [7:0] st,
                       input logic gap, input logic [1:0] er);
    int t;
    logic [63:0] d;
    logic [3:0] ix;
    {reqAddress, reqLength, reqSideband, reqExclusive, reqCache} = {a, n, sb, ex, ca};
    reqId4 = n;
    reqValid = 1'b1;
    #1;
    for (t = 0; t < 50 && reqReady !== 1'b1; t++) @(negedge clock);
    waited(t);
    @(negedge clock);
    reqValid = 1'b0;
    for (int k = 0; k <= n; k++) begin
      d = {a, 24'h5A5A00, 4'h0, 4'(k)};
      {beatData, beatStrobe, beatValid} = {d, st, 1'b1};
      #1;
      for (t = 0; t < 50 && beatReady !== 1'b1; t++) @(negedge clock);
      waited(t);
      ix = a[6:3] + 4'(k);
      for (int b = 0; b < 8; b++) if (st[b] && er != RESP_SLVERR) mem[ix][8*b+:8] = d[8*b+:8];
      @(negedge clock);
      if (gap || k == int'(n)) beatValid = 1'b0;
      if (gap) @(negedge clock);
    end
    for (t = 0; t < 50 && doneValid !== 1'b1; t++) @(negedge clock);
    waited(t);
    check(doneResp, er);
    check(lastAttr, sb[4:1]);
    check({lastShared, lastExclusive, lastCacheable}, {sb[0], ex, ca[1]});
    $display("burst at %h length %0d done", a, n);
  endtask : burst
  // Main sequence
  initial begin
    {rstn, reqValid, reqExclusive, beatValid, reqAddress, reqLength} = '0;
    {reqCache, reqId4, reqSideband, beatData, beatStrobe, peekIndex} = '0;
    for (int i = 0; i < MEM_WORDS; i++) mem[i] = '0;
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    for (int i = 0; i < 6; i++) begin
      burst(32'h78 + 32'(i) * 32'h48, 4'(3 * i), {attrs[i], i[0]}, 1'b0, 4'(i),
            8'hFF >> i, i[0], RESP_OKAY);
    end
    burst(32'h10, 4'h2, 5'h05, 1'b0, 4'h2, 8'hFF, 1'b0, RESP_SLVERR);
    burst(32'h20, 4'h1, {ATTR_WBACK_ALLOC, 1'b1}, 1'b1, 4'hF, 8'h81, 1'b1, RESP_EXOKAY);
    for (int i = 0; i < MEM_WORDS; i++) begin
      peekIndex = 4'(i);
      @(negedge clock);
      check(peekData, mem[i]);
    end
    $display("store sweep done");
    summarize();
  end
endmodule : testbench
